// ---- dv/bridge_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module bridge_ctrl_assertions
   import bridge_ctrl_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       irq_out,
   input wire logic       irq_oe_n,
   input wire logic       pll_enable,
   input wire logic       first_link_pin_flip,
   input wire logic       second_link_pin_flip,
   input wire logic       link_swap,
   input wire logic       out_a_flip,
   input wire logic       out_b_flip,
   input wire logic       pattern_gen_on,
   input wire logic       band_is_62m5_87m5,
   input wire logic       in_band_is_490m,
   input wire logic [3:0] lanes_active
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence wr_at(logic [7:0] a);
      reg_wr && reg_addr == a;
   endsequence
   oe_gate_a: assert property (wr_at(irq_gate_addr) |-> ##2 irq_oe_n == !$past(reg_wdata[0], 2))
      else $error("pin enable does not follow gate write");
   irq_released_a: assert property (irq_oe_n |-> !irq_out)
      else $error("interrupt high while pin released");
   pin_flip_a: assert property (wr_at(link_cfg_addr) |-> ##2
      first_link_pin_flip == $past(reg_wdata[5], 2) && second_link_pin_flip == $past(reg_wdata[4], 2))
      else $error("pin flip outputs wrong");
   link_swap_a: assert property (wr_at(link_cfg_addr) |-> ##2 link_swap == $past(reg_wdata[6], 2)
      && out_a_flip == (link_swap ? second_link_pin_flip : first_link_pin_flip)
      && out_b_flip == (link_swap ? first_link_pin_flip : second_link_pin_flip))
      else $error("link exchange wrong");
   pll_en_a: assert property (wr_at(pll_ctl_addr) |-> ##2 pll_enable == $past(reg_wdata[0], 2))
      else $error("pll enable wrong");
   band_dec_a: assert property (wr_at(clk_band_addr) |-> ##2
      band_is_62m5_87m5 == ($past(reg_wdata[3:1], 2) == band_62m5_87m5))
      else $error("pixel band decode wrong");
   in_band_a: assert property (wr_at(in_band_addr) |-> ##2
      in_band_is_490m == ($past(reg_wdata, 2) == in_band_490m))
      else $error("input band decode wrong");
   lane_dec_a: assert property (wr_at(lane_cfg_addr) |-> ##2
      lanes_active == (4'hf >> $past(reg_wdata[4:3], 2)))
      else $error("lane decode wrong");
   pattern_on_a: assert property (wr_at(pattern_addr) |-> ##2 pattern_gen_on == $past(reg_wdata[4], 2))
      else $error("pattern enable wrong");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
endmodule // bridge_ctrl_assertions
bind video_bridge_control_sequencer bridge_ctrl_assertions i_chk (
   .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out),
   .irq_oe_n(irq_oe_n), .pll_enable(pll_enable), .first_link_pin_flip(first_link_pin_flip),
   .second_link_pin_flip(second_link_pin_flip), .link_swap(link_swap),
   .out_a_flip(out_a_flip), .out_b_flip(out_b_flip), .pattern_gen_on(pattern_gen_on),
   .band_is_62m5_87m5(band_is_62m5_87m5), .in_band_is_490m(in_band_is_490m),
   .lanes_active(lanes_active));
`default_nettype wire

// ---- dv/video_bridge_control_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module video_bridge_control_sequencer_tb;
   import bridge_ctrl_pkg::*;
   logic       core_clk = 1'b0;
   logic       srst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       stream_on = 1'b0;
   logic       lock_req = 1'b1;
   logic [6:1] err_req = 6'h00;
   wire logic [7:0] reg_rdata, input_clock_band, lbb, lfb, fbb, ffb;
   wire logic [6:1] err_event;
   wire logic [3:0] lanes_active;
   wire logic [2:0] pixel_clock_band;
   wire logic [1:0] input_lane_count;
   wire logic irq_out, irq_oe_n, pll_enable, logic_reinit, pixel_clock_source, pixel_tick;
   wire logic flip_a, flip_b, link_swap, out_a, out_b, pattern_gen_on, band_ok, in_ok;
   wire logic link_clk_pin, pll_lock_pin;
   int error_cnt = 0;
   int comparisons = 0;
   int seed = 32'h26c589f8;
   int ticks;
   logic [7:0] v, o, p, g;
   always #5 core_clk = ~core_clk;
   video_bridge_control_sequencer i_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .err_event(err_event), .pll_lock_pin(pll_lock_pin), .link_clk_pin(link_clk_pin),
      .irq_out(irq_out), .irq_oe_n(irq_oe_n), .pll_enable(pll_enable),
      .logic_reinit(logic_reinit), .pixel_clock_source(pixel_clock_source),
      .pixel_tick(pixel_tick), .pixel_clock_band(pixel_clock_band),
      .input_clock_band(input_clock_band), .input_lane_count(input_lane_count),
      .lanes_active(lanes_active), .first_link_pin_flip(flip_a),
      .second_link_pin_flip(flip_b), .link_swap(link_swap), .out_a_flip(out_a),
      .out_b_flip(out_b), .pattern_gen_on(pattern_gen_on), .line_back_blank(lbb),
      .line_front_blank(lfb), .frame_back_blank(fbb), .frame_front_blank(ffb),
      .band_is_62m5_87m5(band_ok), .in_band_is_490m(in_ok));
   video_source_model i_src (.stream_on(stream_on), .lock_req(lock_req), .err_req(err_req),
      .link_clk_pin(link_clk_pin), .pll_lock_pin(pll_lock_pin), .err_event(err_event));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge core_clk) reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge core_clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // look just after each edge, once the launched value has settled
   task count_ticks(input int n);
      ticks = 0;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         if (pixel_tick === 1'b1) ticks++;
      end
   endtask
   task pulse(input logic [6:1] e);
      @(posedge core_clk) err_req <= e;
      @(posedge core_clk) err_req <= 6'h00;
   endtask
   function logic [7:0] exp_link(input logic [2:0] i);
      return {3'h0, i[1], i[0], i[2], i[2] ? i[0] : i[1], i[2] ? i[1] : i[0]};
   endfunction
   // back porch is what blanking leaves after offset and pulse
   function logic [7:0] porch(input logic [7:0] blank, input logic [7:0] off, input logic [7:0] pw);
      return blank - (off + pw);
   endfunction
   task end_sim;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #300000;
      error_cnt++;
      end_sim;
   end
   initial begin
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      rd(err_status_addr, v); chk(v, err_status_rst);
      chk({7'h0, irq_oe_n}, 8'h01);
      // full configuration first, pll last
      wr(clk_band_addr, 8'h05); wr(clk_div_addr, {div_by_6_code, 3'h0});
      wr(lane_cfg_addr, 8'h00); wr(in_band_addr, in_band_490m);
      wr(pll_ctl_addr, 8'h01); wt(2);
      chk({band_ok, in_ok, pixel_clock_source, pll_enable, lanes_active}, 8'hff);
      chk({3'h0, pixel_clock_band, input_lane_count}, {3'h0, band_62m5_87m5, lanes_four});
      chk(input_clock_band, in_band_490m);
      rd(status_addr, v); chk(v & 8'h01, 8'h01);
      stream_on <= 1'b1;
      // 204 cycles hold 60 link edges, so ten ticks give or take one
      count_ticks(204);
      chk(8'(ticks >= 9 && ticks <= 11), 8'h01);
      for (int i = 0; i < 8; i++) begin
         wr(link_cfg_addr, 8'(i << 4)); wr(lane_cfg_addr, 8'((i % 4) << 3)); wt(2);
         chk({3'h0, flip_a, flip_b, link_swap, out_a, out_b}, exp_link(3'(i)));
         chk({2'h0, input_lane_count, lanes_active}, {2'h0, 2'(i % 4), 4'hf >> (i % 4)});
      end
      repeat (4) begin
         o = 8'($random(seed)) & 8'h3f; p = 8'($random(seed)) & 8'h3f;
         g = o + p + (8'($random(seed)) & 8'h7f);
         wr(line_back_addr, porch(g, o, p)); wr(line_front_addr, o);
         wr(frame_back_addr, porch(g, p, o)); wr(frame_front_addr, p);
         wr(pattern_addr, {3'h0, g[0], 4'h0}); wt(2);
         chk(lbb, porch(g, o, p)); chk(lfb, o);
         chk(fbb, porch(g, p, o)); chk(ffb, p);
         chk({7'h0, pattern_gen_on}, {7'h0, g[0]});
      end
      wr(err_status_addr, 8'h01); rd(err_status_addr, v); chk(v, 8'h00);
      wr(irq_enable_addr, 8'h08); pulse(6'h04); wt(4);
      chk({6'h0, irq_out, irq_oe_n}, 8'h01);
      wr(irq_gate_addr, 8'h01); wt(2); chk({6'h0, irq_out, irq_oe_n}, 8'h02);
      pulse(6'h02); wr(err_status_addr, 8'h08); wt(3);
      chk({6'h0, irq_out, irq_oe_n}, 8'h00);
      rd(err_status_addr, v); chk(v, 8'h04);
      // stop: pll off, then stream off and lock lost together
      wr(pll_ctl_addr, 8'h00); stream_on <= 1'b0; lock_req <= 1'b0; wt(8);
      rd(err_status_addr, v); chk(v, 8'h05);
      count_ticks(60); chk(8'(ticks), 8'h00);
      wr(err_status_addr, 8'hff); stream_on <= 1'b1; lock_req <= 1'b1;
      // the 3 ms settle is cut to a few cycles to keep the run short
      wr(pll_ctl_addr, 8'h01); wt(30); wr(soft_reset_addr, 8'h01); wt(2);
      chk({6'h0, pll_enable, logic_reinit}, 8'h03);
      // clear and a new event in one cycle: the event must win
      @(posedge core_clk) {err_req, reg_wr, reg_addr, reg_wdata} <=
         {6'h04, 1'b1, err_status_addr, 8'h08};
      @(posedge core_clk) {err_req, reg_wr} <= 7'h00;
      rd(err_status_addr, v); chk(v & 8'h08, 8'h08);
      chk({6'h0, irq_out, irq_oe_n}, 8'h02);
      wr(8'h55, 8'hff); rd(8'h55, v); chk(v, 8'h00);
      end_sim;
   end
endmodule // video_bridge_control_sequencer_tb
`default_nettype wire

// ---- dv/video_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module video_source_model (
   input  wire logic       stream_on,
   input  wire logic       lock_req,
   input  wire logic [6:1] err_req,
   output logic            link_clk_pin,
   output logic            pll_lock_pin,
   output logic [6:1]      err_event
);
   // clock lane stays in fast mode even when data lanes idle
   initial begin
      link_clk_pin = 1'b0;
      forever #17 link_clk_pin = ~link_clk_pin;
   end
   // errors only come from a live stream
   assign err_event    = stream_on ? err_req : 6'h00;
   assign pll_lock_pin = lock_req;
endmodule // video_source_model
`default_nettype wire

// ---- logic/bridge_ctrl_pkg.sv ----
`default_nettype none
package bridge_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] soft_reset_addr   = 8'h09;
   localparam logic [7:0] clk_band_addr     = 8'h0a;
   localparam logic [7:0] clk_div_addr      = 8'h0b;
   localparam logic [7:0] pll_ctl_addr      = 8'h0d;
   localparam logic [7:0] lane_cfg_addr     = 8'h10;
   localparam logic [7:0] in_band_addr      = 8'h12;
   localparam logic [7:0] link_cfg_addr     = 8'h1a;
   localparam logic [7:0] line_back_addr    = 8'h34;
   localparam logic [7:0] frame_back_addr   = 8'h36;
   localparam logic [7:0] line_front_addr   = 8'h38;
   localparam logic [7:0] frame_front_addr  = 8'h3a;
   localparam logic [7:0] pattern_addr      = 8'h3c;
   localparam logic [7:0] irq_gate_addr     = 8'he0;
   localparam logic [7:0] irq_enable_addr   = 8'he1;
   localparam logic [7:0] err_status_addr   = 8'he5;
   localparam logic [7:0] status_addr       = 8'he6;
   // field positions
   localparam int pll_en_bit        = 0;
   localparam int soft_reset_bit    = 0;
   localparam int clk_src_bit       = 0;
   localparam int band_lsb          = 1;
   localparam int div_lsb           = 3;
   localparam int lane_lsb          = 3;
   localparam int second_flip_bit   = 4;
   localparam int first_flip_bit    = 5;
   localparam int link_swap_bit     = 6;
   localparam int pattern_bit       = 4;
   localparam int irq_gate_bit      = 0;
   localparam int lock_lost_bit     = 0;
   // field values
   localparam logic [2:0] band_62m5_87m5 = 3'h2;
   localparam logic [4:0] div_by_6_code  = 5'h02;
   localparam logic [1:0] lanes_four     = 2'h0;
   localparam logic [7:0] in_band_490m   = 8'h62;
   // reset values and error flag mask
   localparam logic [7:0] err_status_rst = 8'h01;
   localparam logic [7:0] zero_rst       = 8'h00;
   localparam logic [7:0] err_mask       = 8'hfd;
endpackage : bridge_ctrl_pkg
`default_nettype wire

// ---- logic/clock_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
   parameter int width = 5
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             enable,
   input  wire logic [width-1:0] factor,
   output logic                  tick
);
   logic [width-1:0] count_q;
   // tick once every factor enable pulses; factor 0 or 1 ticks on each
   // count holds between pulses, else a one-cycle enable never gets past one
   always_ff @(posedge core_clk) begin
      if (srst) begin
         count_q <= '0;
         tick    <= 1'b0;
      end else if (!enable) begin
         tick    <= 1'b0;
      end else if (count_q + width'(1) >= factor) begin
         count_q <= '0;
         tick    <= 1'b1;
      end else begin
         count_q <= count_q + width'(1);
         tick    <= 1'b0;
      end
   end
endmodule // clock_divider
`default_nettype wire

// ---- logic/video_bridge_control_sequencer.sv ----
// What this block does
// - pin order flip of first link by bit 5, second by bit 4.
// - link exchange bit swaps the two output links.
// - interrupt pin driven only while the pin gate bit is set.
// - interrupt asserts when flag, its enable and pin gate are all set; flag bit 1 has no enable.
// - writing one to an error flag clears it, except flag bit 1.
// - reinit during streaming may leave error flags set.
// - link clock as pixel source is divided by the divisor field.
// - band code 010b means 62.5 to 87.5 MHz pixel clock.
// - source bit one takes pixel clock from the input link clock.
// - divisor code 0010b divides the link clock by six.
// - lane count code 00 enables all four data lanes.
// - input band 0x62 means 490 to 495 MHz input clock.
// - pattern enable bit runs the test pattern from timing registers.
// - gate clear leaves interrupt released; gate set drives it with the interrupt state.
// - lock-lost flag sets on every locked to unlocked change.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module video_bridge_control_sequencer
   import bridge_ctrl_pkg::*;
#(
   parameter int div_width = 5
) (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   input  wire logic [6:1] err_event,
   input  wire logic       pll_lock_pin,
   input  wire logic       link_clk_pin,
   output logic            irq_out,
   output logic            irq_oe_n,
   output logic            pll_enable,
   output logic            logic_reinit,
   output logic            pixel_clock_source,
   output logic            pixel_tick,
   output logic [2:0]      pixel_clock_band,
   output logic [7:0]      input_clock_band,
   output logic [1:0]      input_lane_count,
   output logic [3:0]      lanes_active,
   output logic            first_link_pin_flip,
   output logic            second_link_pin_flip,
   output logic            link_swap,
   output logic            out_a_flip,
   output logic            out_b_flip,
   output logic            pattern_gen_on,
   output logic [7:0]      line_back_blank,
   output logic [7:0]      line_front_blank,
   output logic [7:0]      frame_back_blank,
   output logic [7:0]      frame_front_blank,
   output logic            band_is_62m5_87m5,
   output logic            in_band_is_490m
);
   logic [7:0]           band_q;
   logic [7:0]           div_q;
   logic [7:0]           lane_q;
   logic [7:0]           link_q;
   logic [7:0]           pat_q;
   logic [7:0]           gate_q;
   logic [7:0]           en_q;
   logic [7:0]           err_q;
   logic [7:0]           err_d;
   logic                 pll_q;
   logic                 reinit_q;
   logic                 lock_s1_q;
   logic                 lock_s2_q;
   logic                 lock_prev_q;
   logic                 lclk_s1_q;
   logic                 lclk_s2_q;
   logic                 lclk_prev_q;
   logic                 lclk_rise;
   logic                 div_tick;
   logic                 irq_req;
   logic [7:0]           rdata_d;

   // pins come from other domains
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lock_s1_q   <= 1'b0;
         lock_s2_q   <= 1'b0;
         lock_prev_q <= 1'b0;
         lclk_s1_q   <= 1'b0;
         lclk_s2_q   <= 1'b0;
         lclk_prev_q <= 1'b0;
      end else begin
         lock_s1_q   <= pll_lock_pin;
         lock_s2_q   <= lock_s1_q;
         lock_prev_q <= lock_s2_q;
         lclk_s1_q   <= link_clk_pin;
         lclk_s2_q   <= lclk_s1_q;
         lclk_prev_q <= lclk_s2_q;
      end
   end

   assign lclk_rise = lclk_s2_q & ~lclk_prev_q;

   // configuration registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         band_q   <= zero_rst;
         div_q    <= zero_rst;
         lane_q   <= zero_rst;
         link_q   <= zero_rst;
         pat_q    <= zero_rst;
         gate_q   <= zero_rst;
         en_q     <= zero_rst;
         pll_q    <= 1'b0;
         reinit_q <= 1'b0;
         input_clock_band  <= zero_rst;
         line_back_blank   <= zero_rst;
         line_front_blank  <= zero_rst;
         frame_back_blank  <= zero_rst;
         frame_front_blank <= zero_rst;
      end else if (reg_wr) begin
         unique case (reg_addr)
            soft_reset_addr:  reinit_q <= reg_wdata[soft_reset_bit];
            clk_band_addr:    band_q <= reg_wdata;
            clk_div_addr:     div_q <= reg_wdata;
            pll_ctl_addr:     pll_q <= reg_wdata[pll_en_bit];
            lane_cfg_addr:    lane_q <= reg_wdata;
            in_band_addr:     input_clock_band <= reg_wdata;
            link_cfg_addr:    link_q <= reg_wdata;
            line_back_addr:   line_back_blank <= reg_wdata;
            frame_back_addr:  frame_back_blank <= reg_wdata;
            line_front_addr:  line_front_blank <= reg_wdata;
            frame_front_addr: frame_front_blank <= reg_wdata;
            pattern_addr:     pat_q <= reg_wdata;
            irq_gate_addr:    gate_q <= reg_wdata;
            irq_enable_addr:  en_q <= reg_wdata & err_mask;
            default: begin
            end
         endcase
      end
   end

   // error flags: hardware set beats host clear
   always_comb begin
      err_d = err_q;
      if (reg_wr && reg_addr == err_status_addr) begin
         err_d = err_q & ~(reg_wdata & err_mask);
      end
      err_d[6:1] = err_d[6:1] | err_event;
      if (lock_prev_q && !lock_s2_q) begin
         err_d[lock_lost_bit] = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         err_q <= err_status_rst;
      end else begin
         err_q <= err_d;
      end
   end

   assign irq_req = |(err_q & en_q);

   // pin driven high only while gated; otherwise released
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_out  <= 1'b0;
         irq_oe_n <= 1'b1;
      end else begin
         irq_out  <= gate_q[irq_gate_bit] & irq_req;
         irq_oe_n <= ~gate_q[irq_gate_bit];
      end
   end

   // status tick from divided link clock; divider counts link edges
   clock_divider #(
      .width(div_width)
   ) u_div (
      .core_clk (core_clk),
      .srst     (srst),
      .enable   (lclk_rise),
      .factor   (div_q[div_lsb +: div_width]),
      .tick     (div_tick)
   );

   // divider code n divides by n plus 4, so 0010b gives six
   logic [div_width-1:0] div_cnt_q;
   logic [div_width-1:0] div_target;
   assign div_target = div_q[div_lsb +: div_width] + div_width'(3);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         div_cnt_q  <= '0;
         pixel_tick <= 1'b0;
      end else if (!pll_q || !band_q[clk_src_bit]) begin
         div_cnt_q  <= '0;
         pixel_tick <= 1'b0;
      end else if (lclk_rise) begin
         if (div_cnt_q >= div_target) begin
            div_cnt_q  <= '0;
            pixel_tick <= 1'b1;
         end else begin
            div_cnt_q  <= div_cnt_q + div_width'(1);
            pixel_tick <= 1'b0;
         end
      end else begin
         pixel_tick <= 1'b0;
      end
   end

   // decoded configuration, all registered
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pll_enable           <= 1'b0;
         logic_reinit         <= 1'b0;
         pixel_clock_source   <= 1'b0;
         pixel_clock_band     <= 3'h0;
         input_lane_count     <= 2'h0;
         lanes_active         <= 4'h0;
         first_link_pin_flip  <= 1'b0;
         second_link_pin_flip <= 1'b0;
         link_swap            <= 1'b0;
         out_a_flip           <= 1'b0;
         out_b_flip           <= 1'b0;
         pattern_gen_on       <= 1'b0;
         band_is_62m5_87m5    <= 1'b0;
         in_band_is_490m      <= 1'b0;
      end else begin
         pll_enable           <= pll_q;
         logic_reinit         <= reinit_q;
         pixel_clock_source   <= band_q[clk_src_bit];
         pixel_clock_band     <= band_q[band_lsb +: 3];
         band_is_62m5_87m5    <= band_q[band_lsb +: 3] == band_62m5_87m5;
         in_band_is_490m      <= input_clock_band == in_band_490m;
         input_lane_count     <= lane_q[lane_lsb +: 2];
         // lane code counts down from four lanes
         unique case (lane_q[lane_lsb +: 2])
            lanes_four: lanes_active <= 4'hf;
            2'h1:       lanes_active <= 4'h7;
            2'h2:       lanes_active <= 4'h3;
            2'h3:       lanes_active <= 4'h1;
         endcase
         first_link_pin_flip  <= link_q[first_flip_bit];
         second_link_pin_flip <= link_q[second_flip_bit];
         link_swap            <= link_q[link_swap_bit];
         // flip follows the link to whichever output it lands on
         out_a_flip <= link_q[link_swap_bit] ? link_q[second_flip_bit]
                                             : link_q[first_flip_bit];
         out_b_flip <= link_q[link_swap_bit] ? link_q[first_flip_bit]
                                             : link_q[second_flip_bit];
         pattern_gen_on <= pat_q[pattern_bit];
      end
   end

   // read mux; unmapped reads return zero
   always_comb begin
      rdata_d = 8'h00;
      unique case (reg_addr)
         soft_reset_addr:  rdata_d = {7'h00, reinit_q};
         clk_band_addr:    rdata_d = band_q;
         clk_div_addr:     rdata_d = div_q;
         pll_ctl_addr:     rdata_d = {7'h00, pll_q};
         lane_cfg_addr:    rdata_d = lane_q;
         in_band_addr:     rdata_d = input_clock_band;
         link_cfg_addr:    rdata_d = link_q;
         line_back_addr:   rdata_d = line_back_blank;
         frame_back_addr:  rdata_d = frame_back_blank;
         line_front_addr:  rdata_d = line_front_blank;
         frame_front_addr: rdata_d = frame_front_blank;
         pattern_addr:     rdata_d = pat_q;
         irq_gate_addr:    rdata_d = gate_q;
         irq_enable_addr:  rdata_d = en_q;
         err_status_addr:  rdata_d = err_q;
         status_addr:      rdata_d = {6'h00, div_tick, lock_s2_q};
         default:          rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // host-side ordering (stop, restart, band setup, porch math,
   // clearing flags before restart, streaming after setup) is not
   // enforced here; the block simply reflects what was programmed.
   // lane idle state and porch values are host duties
endmodule // video_bridge_control_sequencer
`default_nettype wire
